// >>> hdl/sfq_queue.sv
/*
 * stream queue top: write and read stream channels, sideband carriage,
 * occupancy count and an AXI4-Lite register slave.
 * assumes one clock for everything and synchronous stream partners.
 */
// Functional notes
// - write ready only high while a word can be accepted
// - a word moves only on an edge with valid and ready both high
// - requested depth is a word count between 16 and 128K
// - depth actually built is reported, may exceed the request
// - payload width is a whole number of bytes
// - strobe has one bit per byte, bit 0 is the lowest byte
// - keep has one bit per byte, same order; low keep marks null byte
// - packet end marker travels with its own word
// - routing field stored and passed through unchanged
// - stream identifier stored and passed through unchanged
// - user sideband stored and passed through unchanged
// - optional global reset input chosen by a build parameter
// - optional occupancy output, log2 of depth plus one bits wide
// - occupancy never shows fewer words than are stored
// - a written word shows in the occupancy one edge later
// - one common clock; block or distributed storage at build time
`timescale 1ns/10ps
module sfq_queue #(
  parameter int DEPTH = 16,
  parameter bit USE_BLOCK_RAM = 1'b0,
  parameter bit HAS_GLOBAL_RST = 1'b1,
  parameter bit HAS_COUNT = 1'b1,
  parameter bit HAS_STRB = 1'b1,
  parameter bit HAS_KEEP = 1'b1,
  parameter bit HAS_LAST = 1'b1,
  parameter bit HAS_DEST = 1'b1,
  parameter bit HAS_ID = 1'b1,
  parameter bit HAS_USER = 1'b1,
  parameter int CNT_W = $clog2(DEPTH) + 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic queue_rst_n,
  // write channel
  input wire logic s_axis_tvalid,
  output logic s_axis_tready,
  input wire logic [sfq_pkg::SFQ_DATA_W-1:0] s_axis_tdata,
  input wire logic [sfq_pkg::SFQ_BYTES-1:0] s_axis_tstrb,
  input wire logic [sfq_pkg::SFQ_BYTES-1:0] s_axis_tkeep,
  input wire logic s_axis_tlast,
  input wire logic [sfq_pkg::SFQ_DEST_W-1:0] s_axis_tdest,
  input wire logic [sfq_pkg::SFQ_ID_W-1:0] s_axis_tid,
  input wire logic [sfq_pkg::SFQ_USER_W-1:0] s_axis_tuser,
  // read channel
  output logic m_axis_tvalid,
  input wire logic m_axis_tready,
  output logic [sfq_pkg::SFQ_DATA_W-1:0] m_axis_tdata,
  output logic [sfq_pkg::SFQ_BYTES-1:0] m_axis_tstrb,
  output logic [sfq_pkg::SFQ_BYTES-1:0] m_axis_tkeep,
  output logic m_axis_tlast,
  output logic [sfq_pkg::SFQ_DEST_W-1:0] m_axis_tdest,
  output logic [sfq_pkg::SFQ_ID_W-1:0] m_axis_tid,
  output logic [sfq_pkg::SFQ_USER_W-1:0] m_axis_tuser,
  output logic [CNT_W-1:0] data_count,
  output logic [31:0] actual_depth,
  // register port
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  output logic [1:0] s_axil_bresp,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  input wire logic [7:0] s_axil_araddr,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp
);
  // ------------------------------------------------------------
  // sizing
  // ------------------------------------------------------------
  // out-of-range requests are clamped rather than rejected
  localparam int DEPTH_C = (DEPTH < sfq_pkg::SFQ_DEPTH_MIN) ?
    sfq_pkg::SFQ_DEPTH_MIN : (DEPTH > sfq_pkg::SFQ_DEPTH_MAX) ?
    sfq_pkg::SFQ_DEPTH_MAX : DEPTH;
  localparam int MEM_D = 1 << $clog2(DEPTH_C);
  // block storage carries one more word in its output stage
  localparam int ACT_D = MEM_D + (USE_BLOCK_RAM ? 1 : 0);
  localparam int LVL_W = $clog2(MEM_D) + 2;
  localparam int WW = $bits(sfq_pkg::sfq_word_s);

  logic rst_n, flush, hold;
  logic in_ready, out_valid, in_hs, out_hs;
  logic [LVL_W-1:0] level;
  sfq_pkg::sfq_word_s in_word;
  sfq_pkg::sfq_word_s out_word;
  logic [31:0] pkt_cnt, byte_cnt, posn_cnt;

  // queue reset joins block reset and the optional global one
  assign rst_n = aresetn && (!HAS_GLOBAL_RST || queue_rst_n);

  // ------------------------------------------------------------
  // stream channels
  // ------------------------------------------------------------
  // absent fields are stored as their idle values
  always_comb begin
    in_word.data = s_axis_tdata;
    in_word.strb = HAS_STRB ? s_axis_tstrb : '1;
    in_word.keep = HAS_KEEP ? s_axis_tkeep : '1;
    in_word.last = HAS_LAST ? s_axis_tlast : 1'b0;
    in_word.dest = HAS_DEST ? s_axis_tdest : '0;
    in_word.id = HAS_ID ? s_axis_tid : '0;
    in_word.user = HAS_USER ? s_axis_tuser : '0;
  end

  // ready and valid forced low in reset and flush
  assign s_axis_tready = in_ready && rst_n && !flush;
  assign m_axis_tvalid = out_valid && rst_n && !flush && !hold;
  assign in_hs = s_axis_tvalid && s_axis_tready;
  assign out_hs = m_axis_tvalid && m_axis_tready;

  sfq_fifo #(
    .W(WW),
    .DEPTH(MEM_D),
    .OUT_REG(USE_BLOCK_RAM),
    .LVL_W(LVL_W)
  ) u_fifo (
    .clk(aclk),
    .rst_n(rst_n),
    .flush(flush),
    .in_valid(in_hs),
    .in_ready(in_ready),
    .in_data(in_word),
    .out_valid(out_valid),
    .out_ready(out_hs),
    .out_data(out_word),
    .level(level)
  );

  // outputs straight from storage flops, fields unchanged
  assign m_axis_tdata = out_word.data;
  assign m_axis_tstrb = out_word.strb;
  assign m_axis_tkeep = out_word.keep;
  assign m_axis_tlast = out_word.last;
  assign m_axis_tdest = out_word.dest;
  assign m_axis_tid = out_word.id;
  assign m_axis_tuser = out_word.user;
  assign data_count = HAS_COUNT ? CNT_W'(level) : '0;
  assign actual_depth = 32'(ACT_D);

  sfq_stats u_stats (
    .clk(aclk),
    .rst_n(rst_n),
    .beat(out_hs),
    .word(out_word),
    .pkt_cnt(pkt_cnt),
    .byte_cnt(byte_cnt),
    .posn_cnt(posn_cnt)
  );

  // ------------------------------------------------------------
  // register slave, write side
  // ------------------------------------------------------------
  sfq_pkg::sfq_wr_e wr_st;
  logic aw_got, w_got;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic aw_hs, w_hs, wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign s_axil_awready = (wr_st == sfq_pkg::SFQ_WR_IDLE) && !aw_got;
  assign s_axil_wready = (wr_st == sfq_pkg::SFQ_WR_IDLE) && !w_got;
  assign aw_hs = s_axil_awvalid && s_axil_awready;
  assign w_hs = s_axil_wvalid && s_axil_wready;
  // address and data may come in either order
  assign wr_fire = (wr_st == sfq_pkg::SFQ_WR_IDLE) &&
                   (aw_got || aw_hs) && (w_got || w_hs);
  assign wr_addr = aw_got ? aw_q : s_axil_awaddr;
  assign wr_data = w_got ? w_q : s_axil_wdata;
  assign wr_strb = w_got ? ws_q : s_axil_wstrb;
  assign s_axil_bvalid = wr_st == sfq_pkg::SFQ_WR_RESP;

  // write channel sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st <= sfq_pkg::SFQ_WR_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      s_axil_bresp <= sfq_pkg::SFQ_RESP_OKAY;
    end else begin
      case (wr_st)
        sfq_pkg::SFQ_WR_IDLE: begin
          if (aw_hs) begin
            aw_got <= 1'b1;
            aw_q <= s_axil_awaddr;
          end
          if (w_hs) begin
            w_got <= 1'b1;
            w_q <= s_axil_wdata;
            ws_q <= s_axil_wstrb;
          end
          if (wr_fire) begin
            wr_st <= sfq_pkg::SFQ_WR_RESP;
            s_axil_bresp <= (wr_addr == sfq_pkg::SFQ_CTRL_OFS) ?
              sfq_pkg::SFQ_RESP_OKAY : sfq_pkg::SFQ_RESP_SLVERR;
          end
        end
        sfq_pkg::SFQ_WR_RESP: begin
          if (s_axil_bready) begin
            wr_st <= sfq_pkg::SFQ_WR_IDLE;
            aw_got <= 1'b0;
            w_got <= 1'b0;
          end
        end
        default: begin
          wr_st <= sfq_pkg::SFQ_WR_IDLE;
        end
      endcase
    end
  end

  // control: flush is a one-cycle pulse, hold stalls the read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flush <= 1'b0;
      hold <= sfq_pkg::SFQ_HOLD_RST;
    end else begin
      flush <= wr_fire && wr_strb[0] &&
               (wr_addr == sfq_pkg::SFQ_CTRL_OFS) &&
               wr_data[sfq_pkg::SFQ_CTRL_FLUSH_BIT];
      if (wr_fire && wr_strb[0] && (wr_addr == sfq_pkg::SFQ_CTRL_OFS)) begin
        hold <= wr_data[sfq_pkg::SFQ_CTRL_HOLD_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // register slave, read side
  // ------------------------------------------------------------
  sfq_pkg::sfq_rd_e rd_st;
  logic [31:0] stat_word;

  assign stat_word = (32'(level) << sfq_pkg::SFQ_STAT_LVL_LSB) |
    (32'(level == LVL_W'(ACT_D)) << sfq_pkg::SFQ_STAT_FULL_BIT) |
    (32'(level == '0) << sfq_pkg::SFQ_STAT_EMPTY_BIT);
  assign s_axil_arready = rd_st == sfq_pkg::SFQ_RD_IDLE;
  assign s_axil_rvalid = rd_st == sfq_pkg::SFQ_RD_DATA;

  // read data captured at the address edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st <= sfq_pkg::SFQ_RD_IDLE;
      s_axil_rdata <= 32'h0;
      s_axil_rresp <= sfq_pkg::SFQ_RESP_OKAY;
    end else begin
      case (rd_st)
        sfq_pkg::SFQ_RD_IDLE: begin
          if (s_axil_arvalid) begin
            rd_st <= sfq_pkg::SFQ_RD_DATA;
            s_axil_rresp <= sfq_pkg::SFQ_RESP_OKAY;
            case (s_axil_araddr)
              sfq_pkg::SFQ_CTRL_OFS:
                s_axil_rdata <= 32'(hold) << sfq_pkg::SFQ_CTRL_HOLD_BIT;
              sfq_pkg::SFQ_STAT_OFS: s_axil_rdata <= stat_word;
              sfq_pkg::SFQ_DEPTH_OFS: s_axil_rdata <= actual_depth;
              sfq_pkg::SFQ_PKTS_OFS: s_axil_rdata <= pkt_cnt;
              sfq_pkg::SFQ_BYTES_OFS: s_axil_rdata <= byte_cnt;
              sfq_pkg::SFQ_POSN_OFS: s_axil_rdata <= posn_cnt;
              default: begin
                s_axil_rdata <= 32'h0;
                s_axil_rresp <= sfq_pkg::SFQ_RESP_SLVERR;
              end
            endcase
          end
        end
        sfq_pkg::SFQ_RD_DATA: begin
          if (s_axil_rready) begin
            rd_st <= sfq_pkg::SFQ_RD_IDLE;
          end
        end
        default: begin
          rd_st <= sfq_pkg::SFQ_RD_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // assertions and cover points
  // ------------------------------------------------------------
  logic [LVL_W-1:0] shadow;

  // independent word count from the port handshakes
  always_ff @(posedge aclk) begin
    if (!rst_n || flush) begin
      shadow <= '0;
    end else begin
      shadow <= shadow + LVL_W'(in_hs) - LVL_W'(out_hs);
    end
  end

  ready_has_room_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axis_tready |-> level < LVL_W'(ACT_D))
    else $error("write ready while queue full");
  count_tracks_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    level == shadow)
    else $error("occupancy differs from words stored");
  count_next_edge_a: assert property (
    @(posedge aclk) disable iff (!rst_n || flush)
    in_hs && !out_hs ##1 !flush && rst_n |-> level == $past(level) + 1'b1)
    else $error("write not counted at next edge");
  count_idle_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rst_n && !flush && !in_hs && !out_hs |=> $stable(level))
    else $error("occupancy moved without a transfer");
  reset_quiet_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !rst_n |-> !s_axis_tready && !m_axis_tvalid)
    else $error("handshake active during reset");
  reset_empty_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !rst_n |=> level == '0)
    else $error("queue not emptied by reset");
  valid_when_stored_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rst_n && !flush && !hold && $past(level) != '0 && level != '0
    |-> m_axis_tvalid)
    else $error("stored word not offered");
  full_blocks_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    level == LVL_W'(ACT_D) |-> !s_axis_tready)
    else $error("write ready while full");
  out_stable_a: assert property (
    @(posedge aclk) disable iff (!rst_n || flush)
    m_axis_tvalid && !m_axis_tready && !hold ##1 !flush && rst_n
    |-> $stable(m_axis_tdata) && $stable(m_axis_tlast))
    else $error("offered word changed before transfer");
  unused_dest_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !HAS_DEST && m_axis_tvalid |-> m_axis_tdest == '0)
    else $error("disabled routing field not idle");
  bresp_held_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
    else $error("write response dropped early");

  fill_c: cover property (
    @(posedge aclk) disable iff (!aresetn) level == LVL_W'(ACT_D));
  pkt_end_c: cover property (
    @(posedge aclk) disable iff (!aresetn) out_hs && m_axis_tlast);
  hold_fill_c: cover property (
    @(posedge aclk) disable iff (!aresetn) hold && !s_axis_tready);
  flush_c: cover property (
    @(posedge aclk) disable iff (!aresetn) flush && level != '0);
endmodule

// >>> hdl/sfq_pkg.sv
/*
 * shared constants, register map and carrier types for the stream queue.
 * assumes one clock domain and an AXI4-Lite register port on the top.
 */
package sfq_pkg;
  // ------------------------------------------------------------
  // payload and sideband widths
  // ------------------------------------------------------------
  localparam int SFQ_BYTES = 8;
  localparam int SFQ_DATA_W = 8 * SFQ_BYTES;
  localparam int SFQ_DEST_W = 4;
  localparam int SFQ_ID_W = 4;
  localparam int SFQ_USER_W = 8;
  localparam int SFQ_DEPTH_MIN = 16;
  localparam int SFQ_DEPTH_MAX = 131072;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] SFQ_CTRL_OFS = 8'h00;
  localparam logic [7:0] SFQ_STAT_OFS = 8'h04;
  localparam logic [7:0] SFQ_DEPTH_OFS = 8'h08;
  localparam logic [7:0] SFQ_PKTS_OFS = 8'h0c;
  localparam logic [7:0] SFQ_BYTES_OFS = 8'h10;
  localparam logic [7:0] SFQ_POSN_OFS = 8'h14;
  localparam int SFQ_CTRL_FLUSH_BIT = 0;
  localparam int SFQ_CTRL_HOLD_BIT = 1;
  localparam logic SFQ_HOLD_RST = 1'h0;
  localparam int SFQ_STAT_EMPTY_BIT = 0;
  localparam int SFQ_STAT_FULL_BIT = 1;
  localparam int SFQ_STAT_LVL_LSB = 8;
  localparam logic [1:0] SFQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] SFQ_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [SFQ_DATA_W-1:0] data;
    logic [SFQ_BYTES-1:0] strb;
    logic [SFQ_BYTES-1:0] keep;
    logic last;
    logic [SFQ_DEST_W-1:0] dest;
    logic [SFQ_ID_W-1:0] id;
    logic [SFQ_USER_W-1:0] user;
  } sfq_word_s;

  typedef enum logic [1:0] {
    SFQ_WR_IDLE = 2'b01,
    SFQ_WR_RESP = 2'b10
  } sfq_wr_e;

  typedef enum logic [1:0] {
    SFQ_RD_IDLE = 2'b01,
    SFQ_RD_DATA = 2'b10
  } sfq_rd_e;

  // number of set byte qualifiers in one word
  function automatic logic [7:0] sfq_ones(input logic [SFQ_BYTES-1:0] b);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < SFQ_BYTES; i++) begin
      n = n + {7'h00, b[i]};
    end
    return n;
  endfunction
endpackage

// >>> hdl/sfq_fifo.sv
/*
 * storage of the queue: word array, pointers, optional output register.
 * assumes a synchronous active-low reset and a power-of-two depth.
 */
`timescale 1ns/10ps
module sfq_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter bit OUT_REG = 1'b0,
  parameter int LVL_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [LVL_W-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic mem_empty;
  logic mem_full;
  logic push;
  logic pop;
  logic mem_pop;

  // extra pointer bit tells full from empty
  assign mem_empty = wr_ptr == rd_ptr;
  assign mem_full = (wr_ptr[AW] != rd_ptr[AW]) &&
                    (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !mem_full;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // array needs no reset, so it maps onto plain memory
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (mem_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  generate
    if (OUT_REG) begin : g_reg
      logic ovld;
      logic [W-1:0] odata;
      // prefetch into the output stage; adds one word of capacity
      assign mem_pop = !mem_empty && (!ovld || out_ready);
      always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
          ovld <= 1'b0;
        end else if (mem_pop) begin
          ovld <= 1'b1;
        end else if (out_ready) begin
          ovld <= 1'b0;
        end
      end
      always_ff @(posedge clk) begin
        if (mem_pop) begin
          odata <= mem[rd_ptr[AW-1:0]];
        end
      end
      assign out_valid = ovld;
      assign out_data = odata;
    end else begin : g_dist
      assign mem_pop = pop;
      assign out_valid = !mem_empty;
      assign out_data = mem[rd_ptr[AW-1:0]];
    end
  endgenerate

  // occupancy moves the edge after the transfer
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      level <= '0;
    end else begin
      level <= level + LVL_W'(push) - LVL_W'(pop);
    end
  end
endmodule

// >>> hdl/sfq_stats.sv
/*
 * traffic statistics on the read channel: packets, data and position bytes.
 * assumes beat is a one-cycle transfer strobe with its word beside it.
 */
`timescale 1ns/10ps
module sfq_stats (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic beat,
  input wire sfq_pkg::sfq_word_s word,
  output logic [31:0] pkt_cnt,
  output logic [31:0] byte_cnt,
  output logic [31:0] posn_cnt
);
  // counters wrap; software takes differences
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pkt_cnt <= 32'h0;
      byte_cnt <= 32'h0;
      posn_cnt <= 32'h0;
    end else if (beat) begin
      pkt_cnt <= pkt_cnt + {31'h0, word.last};
      byte_cnt <= byte_cnt +
                  {24'h0, sfq_pkg::sfq_ones(word.keep & word.strb)};
      posn_cnt <= posn_cnt +
                  {24'h0, sfq_pkg::sfq_ones(word.keep & ~word.strb)};
    end
  end
endmodule

// >>> verification/sfq_sink.sv
/*
 * downstream stream slave for the queue's read channel.
 * assumes one clock shared with the queue; stalls at random when enabled.
 */
`timescale 1ns/10ps
module sfq_sink (
  input wire logic aclk,
  input wire logic en,
  output logic m_axis_tready
);
  int seed = 32'h5a17c3e1;

  // ready drops about one cycle in four to stall the queue
  initial m_axis_tready = 1'b0;
  always @(posedge aclk) begin
    m_axis_tready <= en && ($random(seed) % 4 != 0);
  end
endmodule

// >>> verification/stream_fifo_queue_tb.sv
/*
 * self-checking bench for the stream queue: random words, register port,
 * hold, fill to refusal, drain with stalls, queue reset with words stored.
 * assumes default build: depth 16, all sideband fields present.
 */
`timescale 1ns/10ps
module stream_fifo_queue_tb;
  logic aclk, aresetn, queue_rst_n, s_axis_tvalid, s_axis_tready;
  logic m_axis_tvalid, m_axis_tready, s_axis_tlast, m_axis_tlast;
  logic [63:0] s_axis_tdata, m_axis_tdata;
  logic [7:0] s_axis_tstrb, s_axis_tkeep, s_axis_tuser;
  logic [7:0] m_axis_tstrb, m_axis_tkeep, m_axis_tuser;
  logic [3:0] s_axis_tdest, s_axis_tid, m_axis_tdest, m_axis_tid;
  logic [4:0] data_count;
  logic [31:0] actual_depth, s_axil_wdata, s_axil_rdata;
  logic [7:0] s_axil_awaddr, s_axil_araddr;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
  logic s_axil_rvalid, s_axil_rready;
  logic en, on, busy, hold;
  sfq_pkg::sfq_word_s sw, mw, e, w;
  sfq_pkg::sfq_word_s q[$];
  int seed = 32'h83912a49;
  int mc, pk, by, po, n_errors, compares;

  assign {s_axis_tdata, s_axis_tstrb, s_axis_tkeep, s_axis_tlast,
          s_axis_tdest, s_axis_tid, s_axis_tuser} = sw;
  assign mw = {m_axis_tdata, m_axis_tstrb, m_axis_tkeep, m_axis_tlast,
               m_axis_tdest, m_axis_tid, m_axis_tuser};

  sfq_queue u_dut (.*);
  sfq_sink u_sink (.aclk(aclk), .en(en), .m_axis_tready(m_axis_tready));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task summarize;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic sfq_pkg::sfq_word_s rw();
    logic [127:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    return r[96:0];
  endfunction

  // valid held with its word until the edge that takes it
  task automatic sput(input sfq_pkg::sfq_word_s x);
    sw <= x;
    s_axis_tvalid <= 1'b1;
    do @(posedge aclk); while (!s_axis_tready);
    q.push_back(x);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic ad, wd;
    busy = 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    if (a == 8'h00) hold = d[1];
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axil_awready && !ad) begin
        ad = 1'b1;
        s_axil_awvalid <= 1'b0;
      end
      if (s_axil_wready && !wd) begin
        wd = 1'b1;
        s_axil_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axil_bvalid);
    s_axil_bready <= 1'b0;
    chk(s_axil_bresp, er);
    @(posedge aclk) busy = 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do @(posedge aclk); while (!s_axil_arready);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axil_rvalid);
    s_axil_rready <= 1'b0;
    chk(s_axil_rdata, ed);
    chk(s_axil_rresp, er);
  endtask

  task automatic drain;
    while (q.size() != 0) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask

  // --------------------------------------------------------------
  // clock, watchdog, stream monitor
  // --------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // span covers the four tests with wide margin
  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  // occupancy, readiness and word order tracked edge by edge
  always @(posedge aclk) begin
    if (on) begin
      chk(data_count, mc);
      chk(s_axis_tready, mc < 16 && queue_rst_n);
      if (!busy) chk(m_axis_tvalid, mc != 0 && !hold && queue_rst_n);
    end
    if (m_axis_tvalid && m_axis_tready) begin
      e = q.pop_front();
      chk(mw, e);
      pk += e.last;
      by += $countones(e.keep & e.strb);
      po += $countones(e.keep & ~e.strb);
    end
    if (!queue_rst_n || !aresetn) mc = 0;
    else mc += (s_axis_tvalid && s_axis_tready) - (m_axis_tvalid && m_axis_tready);
    if (!queue_rst_n) begin
      q.delete();
      pk = 0;
      by = 0;
      po = 0;
    end
  end

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    {aresetn, s_axis_tvalid, en, on, busy, hold} = '0;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
    {s_axil_arvalid, s_axil_rready, s_axil_awaddr, s_axil_araddr} = '0;
    {pk, by, po, mc, n_errors, compares} = '0;
    queue_rst_n = 1'b1;
    s_axil_wdata = '0;
    s_axil_wstrb = 4'hf;
    sw = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    on = 1'b1;
    chk(actual_depth, 32'h10);
    axr(sfq_pkg::SFQ_DEPTH_OFS, 32'h10, sfq_pkg::SFQ_RESP_OKAY);
    axr(8'h40, 32'h0, sfq_pkg::SFQ_RESP_SLVERR);
    axw(sfq_pkg::SFQ_DEPTH_OFS, 32'h5, sfq_pkg::SFQ_RESP_SLVERR);
    $display("test registers done");
    axw(sfq_pkg::SFQ_CTRL_OFS, 32'h2, sfq_pkg::SFQ_RESP_OKAY);
    for (int i = 0; i < 16; i++) sput(rw());
    s_axis_tvalid <= 1'b0;
    repeat (3) @(posedge aclk);
    axr(sfq_pkg::SFQ_STAT_OFS, 32'h1002, sfq_pkg::SFQ_RESP_OKAY);
    en = 1'b1;
    axw(sfq_pkg::SFQ_CTRL_OFS, 32'h0, sfq_pkg::SFQ_RESP_OKAY);
    drain();
    $display("test fill and drain done");
    for (int i = 0; i < 40; i++) begin
      w = rw();
      if (i == 0) w.keep = 8'h00;
      if (i == 1) w.strb = 8'h00;
      sput(w);
    end
    s_axis_tvalid <= 1'b0;
    drain();
    axr(sfq_pkg::SFQ_PKTS_OFS, pk, sfq_pkg::SFQ_RESP_OKAY);
    axr(sfq_pkg::SFQ_BYTES_OFS, by, sfq_pkg::SFQ_RESP_OKAY);
    axr(sfq_pkg::SFQ_POSN_OFS, po, sfq_pkg::SFQ_RESP_OKAY);
    $display("test streaming done");
    axw(sfq_pkg::SFQ_CTRL_OFS, 32'h2, sfq_pkg::SFQ_RESP_OKAY);
    for (int i = 0; i < 5; i++) sput(rw());
    s_axis_tvalid <= 1'b0;
    // flush with hold kept: stored words dropped, count back to zero
    on = 1'b0;
    axw(sfq_pkg::SFQ_CTRL_OFS, 32'h3, sfq_pkg::SFQ_RESP_OKAY);
    q.delete();
    mc = 0;
    on = 1'b1;
    axr(sfq_pkg::SFQ_STAT_OFS, 32'h1, sfq_pkg::SFQ_RESP_OKAY);
    for (int i = 0; i < 5; i++) sput(rw());
    s_axis_tvalid <= 1'b0;
    @(posedge aclk) queue_rst_n <= 1'b0;
    repeat (2) @(posedge aclk);
    queue_rst_n <= 1'b1;
    axr(sfq_pkg::SFQ_PKTS_OFS, 32'h0, sfq_pkg::SFQ_RESP_OKAY);
    axw(sfq_pkg::SFQ_CTRL_OFS, 32'h0, sfq_pkg::SFQ_RESP_OKAY);
    repeat (4) @(posedge aclk);
    $display("test queue reset done");
    summarize();
  end
endmodule
